// ===== cmp_consts.svh
`ifndef CMP_CONSTS_SVH
`define CMP_CONSTS_SVH
// register byte offsets on the AXI4-Lite slave
`define OFS_CMP_CTRL     4'h0
`define OFS_REF_CTRL     4'h4
`define OFS_IRQ_STAT     4'h8
`define OFS_IRQ_MASK     4'hC
// comparator control field positions
`define B_IDLE_STOP      15
`define B_CMP2_FLAG      13
`define B_CMP1_FLAG      12
`define B_CMP2_ON        11
`define B_CMP1_ON        10
`define B_CMP2_PAD       9
`define B_CMP1_PAD       8
`define B_CMP2_RESULT    7
`define B_CMP1_RESULT    6
`define B_CMP2_FLIP      5
`define B_CMP1_FLIP      4
`define B_CMP2_MINUS     3
`define B_CMP2_PLUS      2
`define B_CMP1_MINUS     1
`define B_CMP1_PLUS      0
// writable bits of comparator control, bit 14 and results excluded
`define CMP_CTRL_WMASK   16'hBF3F
// reference control field positions
`define B_REF_POWER      7
`define B_REF_PIN        6
`define B_REF_RANGE      5
`define B_REF_SOURCE     4
`define REF_CTRL_WMASK   16'h00FF
`define REG_RESET        16'h0000
`define IRQ_RESET        2'h0
// AXI response codes
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// ===== cmp_pkg.sv
package cmp_pkg;
  typedef logic [15:0] reg16_t;
  typedef logic [3:0]  refCode_t;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_RESP = 2'b01
  } rdState_t;
endpackage

// ===== cmp_sync2.sv
`timescale 1ns/1ns
// two-stage synchroniser; first stage read only by the second
module cmp_sync2 #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;

  // metastability settles in meta_q before anyone looks
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule // cmp_sync2

// ===== cmp_change_det.sv
`timescale 1ns/1ns
// per-channel change detector on synchronised results
module cmp_change_det #(
  parameter int N = 2
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic [N-1:0] level,
  input  wire logic [N-1:0] enable,
  output logic      [N-1:0] changed
);
  logic [N-1:0] last_q;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_ch
      // history runs even while disabled; enabling or a flip can still
      // raise one event as the gated level moves, so software clears after
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          last_q[i] <= 1'b0;
        end else begin
          last_q[i] <= level[i];
        end
      end
      assign changed[i] = enable[i] & (level[i] ^ last_q[i]);
    end
  endgenerate
endmodule // cmp_change_det

// ===== dual_comparator_control.sv
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "cmp_consts.svh"
// Contract
// - idle_stop set and chip idle: no interrupts, comparators stay enabled.
// - change flags bits 13/12 set when comparator 2/1 output changes.
// - enable bits 11/10 turn comparator 2/1 on or off.
// - pad-drive bits 9/8 put result on pad, else pad held off.
// - inversion bits 5/4 invert output before reporting and driving.
// - minus route bits 3/1: one selects plus pin, zero minus pin.
// - reference control bit 7 powers the reference ladder.
// - bit 6 connects the reference level to its pin.
// - bit 5 selects code/24 span or quarter span plus code/32.
// - bit 4 takes span from external pins or analog supply.
// - four-bit level code gives sixteen steps in either range.
// - unimplemented bits read as zero in both registers.
module dual_comparator_control (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // system state and analog side
  input  wire logic        idleMode,
  input  wire logic [1:0]  cmpRaw,
  output logic [1:0]       cmpOn,
  output logic [1:0]       cmpPadOut,
  output logic [1:0]       cmpPadOe,
  output logic [1:0]       cmpMinusRoute,
  output logic [1:0]       cmpPlusRoute,
  output logic             refPowerOn,
  output logic             refPinDrive,
  output logic             refRangeSelect,
  output logic             refSourceSelect,
  output logic [3:0]       refLevelCode,
  output logic             irq
);
  cmp_pkg::reg16_t   cmpCtrl_q;
  cmp_pkg::reg16_t   refCtrl_q;
  logic [1:0]        flag_q;
  logic [1:0]        irqStat_q;
  logic [1:0]        irqMask_q;
  logic [1:0]        rawSync;
  logic [1:0]        result;
  logic [1:0]        changed;
  logic [1:0]        enables;
  logic [1:0]        flips;
  logic              awHeld_q;
  logic              wHeld_q;
  logic [3:0]        awAddr_q;
  logic [31:0]       wData_q;
  logic [3:0]        wStrb_q;
  logic              doWrite;
  logic [15:0]       wMerge;
  logic [15:0]       curVal;
  logic [31:0]       rdWord;
  logic              rdHit;
  logic              wrHit;
  cmp_pkg::rdState_t rdState_q;

  assign enables = {cmpCtrl_q[`B_CMP2_ON], cmpCtrl_q[`B_CMP1_ON]};
  assign flips   = {cmpCtrl_q[`B_CMP2_FLIP], cmpCtrl_q[`B_CMP1_FLIP]};

  // raw analog results are asynchronous to clk_sys
  cmp_sync2 #(.WIDTH(2)) u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .asyncIn (cmpRaw),
    .syncOut (rawSync)
  );

  // inversion applies before report and pad; disabled reads zero
  assign result = (rawSync ^ flips) & enables;

  cmp_change_det #(.N(2)) u_det (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .level   (result),
    .enable  (enables),
    .changed (changed)
  );

  // write address/data capture, either order, held until both present
  assign doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= 4'h0;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  // readies drop while a beat is held so payload cannot be overwritten
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= ~(awHeld_q | (s_axi_awvalid & s_axi_awready))
                       & ~doWrite;
      s_axi_wready  <= ~(wHeld_q | (s_axi_wvalid & s_axi_wready))
                       & ~doWrite;
    end
  end

  // byte-lane merge of the held write against current contents
  always_comb begin
    case (awAddr_q)
      `OFS_CMP_CTRL: curVal = cmpCtrl_q;
      `OFS_REF_CTRL: curVal = refCtrl_q;
      `OFS_IRQ_MASK: curVal = {14'h0000, irqMask_q};
      default:       curVal = 16'h0000;
    endcase
    wMerge[7:0]  = wStrb_q[0] ? wData_q[7:0]  : curVal[7:0];
    wMerge[15:8] = wStrb_q[1] ? wData_q[15:8] : curVal[15:8];
  end

  assign wrHit = (awAddr_q == `OFS_CMP_CTRL) || (awAddr_q == `OFS_REF_CTRL)
              || (awAddr_q == `OFS_IRQ_STAT) || (awAddr_q == `OFS_IRQ_MASK);

  // write response, unmapped addresses answer SLVERR
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control registers; flags and results live elsewhere
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cmpCtrl_q <= `REG_RESET;
      refCtrl_q <= `REG_RESET;
      irqMask_q <= `IRQ_RESET;
    end else if (doWrite) begin
      if (awAddr_q == `OFS_CMP_CTRL) begin
        cmpCtrl_q <= wMerge & `CMP_CTRL_WMASK;
      end
      if (awAddr_q == `OFS_REF_CTRL) begin
        refCtrl_q <= wMerge & `REF_CTRL_WMASK;
      end
      if (awAddr_q == `OFS_IRQ_MASK) begin
        irqMask_q <= wMerge[1:0];
      end
    end
  end

  // change flags: set wins over a software write of zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flag_q <= `IRQ_RESET;
    end else begin
      if (doWrite && awAddr_q == `OFS_CMP_CTRL && wStrb_q[1]) begin
        flag_q <= {wData_q[`B_CMP2_FLAG], wData_q[`B_CMP1_FLAG]}
                  | changed;
      end else begin
        flag_q <= flag_q | changed;
      end
    end
  end

  // sticky interrupt status, write one to clear; idle stop blocks set
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irqStat_q <= `IRQ_RESET;
    end else begin
      logic [1:0] setBits;
      logic [1:0] clrBits;
      setBits = (idleMode && cmpCtrl_q[`B_IDLE_STOP]) ? 2'h0 : changed;
      clrBits = (doWrite && awAddr_q == `OFS_IRQ_STAT && wStrb_q[0])
                ? wData_q[1:0] : 2'h0;
      irqStat_q <= (irqStat_q & ~clrBits) | setBits;
    end
  end

  // one level interrupt; held low in idle when idle stop is set
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_q & irqMask_q)
             & ~(idleMode & cmpCtrl_q[`B_IDLE_STOP]);
    end
  end

  // pad and analog routing outputs, all registered
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cmpOn           <= 2'h0;
      cmpPadOut       <= 2'h0;
      cmpPadOe        <= 2'h0;
      cmpMinusRoute   <= 2'h0;
      cmpPlusRoute    <= 2'h0;
      refPowerOn      <= 1'b0;
      refPinDrive     <= 1'b0;
      refRangeSelect  <= 1'b0;
      refSourceSelect <= 1'b0;
      refLevelCode    <= 4'h0;
    end else begin
      cmpOn         <= enables;
      cmpPadOe      <= {cmpCtrl_q[`B_CMP2_PAD], cmpCtrl_q[`B_CMP1_PAD]};
      // pad data gated too, so nothing leaks when drive is off
      cmpPadOut     <= result & {cmpCtrl_q[`B_CMP2_PAD],
                                 cmpCtrl_q[`B_CMP1_PAD]};
      cmpMinusRoute <= {cmpCtrl_q[`B_CMP2_MINUS],
                        cmpCtrl_q[`B_CMP1_MINUS]};
      cmpPlusRoute  <= {cmpCtrl_q[`B_CMP2_PLUS],
                        cmpCtrl_q[`B_CMP1_PLUS]};
      refPowerOn      <= refCtrl_q[`B_REF_POWER];
      // pin drive meaningless without power; ladder gates both anyway
      refPinDrive     <= refCtrl_q[`B_REF_PIN];
      refRangeSelect  <= refCtrl_q[`B_REF_RANGE];
      refSourceSelect <= refCtrl_q[`B_REF_SOURCE];
      refLevelCode    <= refCtrl_q[3:0];
    end
  end

  // read data assembly; result bits shown live, flags merged in
  always_comb begin
    rdHit  = 1'b1;
    rdWord = 32'h0000_0000;
    case (s_axi_araddr)
      `OFS_CMP_CTRL: begin
        rdWord[15:0] = cmpCtrl_q;
        rdWord[`B_CMP2_FLAG]   = flag_q[1];
        rdWord[`B_CMP1_FLAG]   = flag_q[0];
        rdWord[`B_CMP2_RESULT] = result[1];
        rdWord[`B_CMP1_RESULT] = result[0];
      end
      `OFS_REF_CTRL: rdWord[15:0] = refCtrl_q;
      `OFS_IRQ_STAT: rdWord[1:0]  = irqStat_q;
      `OFS_IRQ_MASK: rdWord[1:0]  = irqMask_q;
      default:       rdHit = 1'b0;
    endcase
  end

  // read channel: one cycle to accept, data next edge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdState_q     <= cmp_pkg::RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      case (rdState_q)
        cmp_pkg::RD_IDLE: begin
          s_axi_arready <= 1'b1;
          if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdWord;
            s_axi_rresp   <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
            rdState_q     <= cmp_pkg::RD_RESP;
          end
        end
        cmp_pkg::RD_RESP: begin
          s_axi_arready <= 1'b0;
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rdState_q    <= cmp_pkg::RD_IDLE;
          end
        end
        default: begin
          rdState_q <= cmp_pkg::RD_IDLE;
        end
      endcase
    end
  end
endmodule // dual_comparator_control

// ===== cmp_ctrl_assertions.sv
`timescale 1ns/1ns
// port-level checks of the comparator control block
module cmp_ctrl_assertions (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  cmpOn,
  input wire logic [1:0]  cmpPadOut,
  input wire logic [1:0]  cmpPadOe,
  input wire logic [1:0]  cmpMinusRoute,
  input wire logic [1:0]  cmpPlusRoute,
  input wire logic        refPowerOn,
  input wire logic        refPinDrive,
  input wire logic        refRangeSelect,
  input wire logic        refSourceSelect,
  input wire logic [3:0]  refLevelCode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [2:0] wAge_q;
  // cycles since the last data beat; settings may only move just after one
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) wAge_q <= 3'h7;
    else if (s_axi_wvalid && s_axi_wready) wAge_q <= 3'h0;
    else if (wAge_q != 3'h7) wAge_q <= wAge_q + 3'h1;
  end
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  property p_wr_ans; s_wr_taken |-> ##[1:3] s_axi_bvalid; endproperty
  property p_b_hold; s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_rd_ans; s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid;
  endproperty
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_aw_busy; s_axi_bvalid |-> !s_axi_awready; endproperty
  property p_upper0; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  property p_pad_gate; !(|(cmpPadOut & ~cmpPadOe & ~$past(cmpPadOe)));
  endproperty
  property p_ref_hold; $changed({refPowerOn, refPinDrive, refRangeSelect,
    refSourceSelect, refLevelCode}) |-> wAge_q <= 3'h5; endproperty
  property p_cmp_hold; $changed({cmpOn, cmpPadOe, cmpMinusRoute,
    cmpPlusRoute}) |-> wAge_q <= 3'h5; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write unanswered");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  a_aw_busy: assert property (p_aw_busy) else $error("address taken early");
  a_upper0: assert property (p_upper0) else $error("upper bits set");
  a_pad_gate: assert property (p_pad_gate) else $error("pad driven");
  a_ref_hold: assert property (p_ref_hold)
    else $error("reference moved alone");
  a_cmp_hold: assert property (p_cmp_hold)
    else $error("routing moved alone");
endmodule // cmp_ctrl_assertions

// ===== cmp_analog_model.sv
`timescale 1ns/1ns
// analog side: pin levels, reference ladder and two comparators
module cmp_analog_model (
  input  wire logic [1:0]      cmpOn,
  input  wire logic            clk_sys,
  input  wire logic [1:0]      cmpPlusRoute,
  input  wire logic [1:0]      cmpMinusRoute,
  input  wire logic            refPowerOn,
  input  wire logic            refRangeSelect,
  input  wire logic            refSourceSelect,
  input  wire logic [3:0]      refLevelCode,
  input  wire logic [1:0][7:0] plusPin,
  input  wire logic [1:0][7:0] minusPin,
  output logic      [1:0]      cmpRaw
);
  int         span, refV, vp, vm;
  logic [1:0] hit;
  logic       junk_q = 1'b0;
  // supply span is 192 units, external span 96, so every step is whole
  always_comb begin
    span = refSourceSelect ? 96 : 192;
    refV = refRangeSelect ? refLevelCode * span / 24
                          : span / 4 + refLevelCode * span / 32;
    if (!refPowerOn) refV = 0;
    for (int i = 0; i < 2; i++) begin
      vp = cmpPlusRoute[i] ? int'(plusPin[i]) : refV;
      vm = cmpMinusRoute[i] ? int'(plusPin[i]) : int'(minusPin[i]);
      hit[i] = vp > vm;
    end
  end
  // a switched-off comparator output means nothing, so let it wander
  always_ff @(posedge clk_sys) junk_q <= ~junk_q;
  assign #7 cmpRaw = (hit & cmpOn) | ({2{junk_q}} & ~cmpOn);
endmodule // cmp_analog_model

// ===== dual_comparator_control_bench.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_errors++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module dual_comparator_control_bench;
  logic        clk_sys = 1'b0, nrst = 1'b0, idleMode = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_rvalid, irq;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        refPowerOn, refPinDrive, refRangeSelect, refSourceSelect;
  logic [1:0]  s_axi_bresp, s_axi_rresp, cmpRaw, cmpOn, cmpPadOut, cmpPadOe;
  logic [1:0]  cmpMinusRoute, cmpPlusRoute;
  logic [3:0]  refLevelCode;
  logic [1:0][7:0] plusPin = {8'h0A, 8'h96}, minusPin = {8'h32, 8'h64};
  logic [31:0] refTab [4] = '{32'hAF, 32'h80, 32'hBF, 32'h2F};
  logic [31:0] refExp [4] = '{32'h40, 32'h0, 32'h0, 32'h0};
  wire  [7:0]  refAll = {refPowerOn, refPinDrive, refRangeSelect,
                         refSourceSelect, refLevelCode};
  wire  [9:0]  cmpAll = {cmpOn, cmpPadOe, cmpPadOut, cmpPlusRoute,
                         cmpMinusRoute};
  int          n_errors = 0, checks_done = 0;
  always #25 clk_sys = ~clk_sys;
  dual_comparator_control uut (.*);
  cmp_analog_model far (.*);
  task automatic results;
    $display("mismatches %0d comparisons %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // write; the trailing edges let the mirrored outputs settle
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    int   n = 0;
    logic ad = 1'b0, wd = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd && s_axi_bvalid) && n < 40) begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready && !ad) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !wd) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b0;
    if (n >= 40) begin n_errors++; results(); end
    `CHK("bresp", er, s_axi_bresp)
    tick(3);
  endtask
  task automatic axr(input logic [3:0] a, input logic [31:0] m, e,
                     input logic [1:0] er);
    int   n = 0;
    logic ac = 1'b0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!(ac && s_axi_rvalid) && n < 40) begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready && !ac) begin
        ac = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end
    s_axi_rready <= 1'b0;
    if (n >= 40) begin n_errors++; results(); end
    `CHK("rresp", er, s_axi_rresp)
    `CHK("rdata", e, s_axi_rdata & m)
  endtask
  initial begin
    tick(20);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++) axr(4'(i * 4), '1, 32'h0, 2'h0);
    axr(4'h2, '1, 32'h0, 2'h2);
    axw(4'h2, 32'hFFFF, 2'h2);
    axw(4'h4, '1, 2'h0);
    axr(4'h4, '1, 32'h00FF, 2'h0);
    `CHK("refAll", 8'hFF, refAll)
    for (int i = 0; i < 16; i++) begin
      axw(4'h4, 32'h80 | i, 2'h0);
      `CHK("level", 4'(i), refLevelCode)
    end
    // comparator 1 plus above minus, comparator 2 below
    axw(4'h0, 32'h0F05, 2'h0);
    tick(8);
    axr(4'h0, 32'hCFFF, 32'h0F45, 2'h0);
    `CHK("cmpAll", 10'h3DC, cmpAll)
    axw(4'h0, 32'h0F05, 2'h0);
    axw(4'h8, 32'h3, 2'h0);
    axr(4'h8, '1, 32'h0, 2'h0);
    minusPin[0] <= 8'hC8;
    tick(8);
    axr(4'h0, '1, 32'h1F05, 2'h0);
    axr(4'h8, '1, 32'h1, 2'h0);
    `CHK("irq", 1'b0, irq)
    axw(4'hC, 32'h1, 2'h0);
    `CHK("irq", 1'b1, irq)
    idleMode <= 1'b1;
    tick(3);
    `CHK("irq", 1'b1, irq)
    axw(4'h0, 32'h9F05, 2'h0);
    `CHK("irq", 1'b0, irq)
    `CHK("on", 2'h3, cmpOn)
    // comparator 2 flips while idle-stopped: flag sets, status must not
    minusPin[1] <= 8'h00;
    tick(8);
    axr(4'h8, '1, 32'h1, 2'h0);
    axr(4'h0, 32'h2000, 32'h2000, 2'h0);
    minusPin[1] <= 8'h32;
    tick(8);
    idleMode <= 1'b0;
    tick(3);
    `CHK("irq", 1'b1, irq)
    axw(4'h0, 32'h0F05, 2'h0);
    axr(4'h0, '1, 32'h0F05, 2'h0);
    axw(4'h8, 32'h1, 2'h0);
    `CHK("irq", 1'b0, irq)
    axw(4'h0, 32'h0F15, 2'h0);
    tick(8);
    axr(4'h0, 32'hC0, 32'h40, 2'h0);
    `CHK("pad", 2'h1, cmpPadOut)
    minusPin[0] <= 8'h00;
    axw(4'h0, 32'h0F07, 2'h0);
    tick(8);
    axr(4'h0, 32'hC0, 32'h0, 2'h0);
    axw(4'h0, 32'h0405, 2'h0);
    tick(8);
    axr(4'h0, 32'hC0, 32'h40, 2'h0);
    `CHK("cmpAll", 10'h10C, cmpAll)
    axw(4'h0, 32'h0005, 2'h0);
    tick(4);
    axr(4'h0, 32'hC0, 32'h0, 2'h0);
    minusPin[0] <= 8'h64;
    axw(4'h0, 32'h0400, 2'h0);
    for (int i = 0; i < 4; i++) begin
      axw(4'h4, refTab[i], 2'h0);
      tick(8);
      axr(4'h0, 32'h40, refExp[i], 2'h0);
    end
    results();
  end
endmodule // dual_comparator_control_bench
bind dual_comparator_control cmp_ctrl_assertions chk (.*);
